// ===== rtl/dac_gain_pkg.sv
// Operation
// (RULE1) Channel 0 upper gain register keeps the two top code bits in [1:0], read and write.
// (RULE2) Channel 0 lower gain register at the next address keeps the eight low code bits.
// (RULE3) Channel 1 upper gain register keeps its two top code bits in [1:0], same coding.
// (RULE4) Channel 1 lower gain register keeps its eight low code bits, read and write.
// (RULE5) Channel 2 upper gain register keeps its two top code bits in [1:0], same coding.
// (RULE6) Channel 2 lower gain register keeps its eight low code bits, read and write.
// (RULE7) Each assembled 10-bit code is twos complement: max positive is largest current.
// (RULE8) All gain fields clear on reset; upper bits [7:2] read zero and ignore writes.
package dac_gain_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 15;
  localparam int DATA_W  = 8;
  localparam int HIGH_W  = 2;
  localparam int CODE_W  = 10;
  localparam int NUM_CH  = 3;
  localparam int CNT_W   = 5;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [14:0] CH0_GAIN_HIGH_OFS = 15'h040;
  localparam logic [14:0] CH0_GAIN_LOW_OFS  = 15'h041;
  localparam logic [14:0] CH1_GAIN_HIGH_OFS = 15'h042;
  localparam logic [14:0] CH1_GAIN_LOW_OFS  = 15'h043;
  localparam logic [14:0] CH2_GAIN_HIGH_OFS = 15'h044;
  localparam logic [14:0] CH2_GAIN_LOW_OFS  = 15'h045;

  localparam logic [1:0]  GAIN_HIGH_RESET   = 2'h0;
  localparam logic [7:0]  GAIN_LOW_RESET    = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ     = 8'h00;
  localparam logic [5:0]  HIGH_RESERVED     = 6'h00;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int          INSTR_W           = 16;
  localparam int          INSTR_READ_BIT    = 15;
  localparam logic [4:0]  INSTR_LAST        = 5'h0f;
  localparam logic [4:0]  DATA_LAST         = 5'h07;
  localparam logic [4:0]  CNT_ZERO          = 5'h00;
  localparam logic [4:0]  CNT_ONE           = 5'h01;
  localparam logic [14:0] ADDR_STEP         = 15'h0001;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_INSTR,
    PH_DATA
  } phase_t;

endpackage

// ===== rtl/pin_sync.sv
module pin_sync
  import dac_gain_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  input  wire logic pin_in,
  output logic      sync_out
);

  logic meta;

  // ----------------------------------------------------------------
  // Two stages, first one read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta     <= pin_in;
      sync_out <= meta;
    end
  end

endmodule

// ===== rtl/dac_fullscale_gain_regs.sv
module dac_fullscale_gain_regs
  import dac_gain_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_csb_n_in,
  input  wire logic        spi_sdio_in,
  output logic             spi_sdio_out,
  output logic             spi_sdio_oe_n_out,
  output logic [9:0]       ch0_fullscale_code_out,
  output logic [9:0]       ch1_fullscale_code_out,
  output logic [9:0]       ch2_fullscale_code_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s;
  logic csb_n_s;
  logic sdio_s;

  pin_sync #(.RESET_VAL(1'b0)) u_sync_sclk
  (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .pin_in     (spi_sclk_in),
    .sync_out   (sclk_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sync_csb
  (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .pin_in     (spi_csb_n_in),
    .sync_out   (csb_n_s)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_sync_sdio
  (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .pin_in     (spi_sdio_in),
    .sync_out   (sdio_s)
  );

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [1:0]        gain_high [NUM_CH];
  logic [7:0]        gain_low  [NUM_CH];

  logic              sclk_prev;
  phase_t            phase;
  phase_t            next_phase;
  logic [4:0]        bit_cnt;
  logic [14:0]       instr_shift;
  logic [7:0]        data_shift;
  logic [7:0]        out_shift;
  logic [14:0]       cur_addr;
  logic              read_mode;

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  function automatic logic [14:0] high_ofs(input int ch);
    case (ch)
      0:       high_ofs = CH0_GAIN_HIGH_OFS;
      1:       high_ofs = CH1_GAIN_HIGH_OFS;
      default: high_ofs = CH2_GAIN_HIGH_OFS;
    endcase
  endfunction

  function automatic logic [14:0] low_ofs(input int ch);
    case (ch)
      0:       low_ofs = CH0_GAIN_LOW_OFS;
      1:       low_ofs = CH1_GAIN_LOW_OFS;
      default: low_ofs = CH2_GAIN_LOW_OFS;
    endcase
  endfunction

  // Reserved upper bits are stitched in as zero here, never stored
  function automatic logic [7:0] read_byte(input logic [14:0] addr,
                                           input logic [1:0]  h0,
                                           input logic [7:0]  l0,
                                           input logic [1:0]  h1,
                                           input logic [7:0]  l1,
                                           input logic [1:0]  h2,
                                           input logic [7:0]  l2);
    case (addr)
      CH0_GAIN_HIGH_OFS: read_byte = {HIGH_RESERVED, h0}; // RULE1 RULE8
      CH0_GAIN_LOW_OFS:  read_byte = l0;                  // RULE2
      CH1_GAIN_HIGH_OFS: read_byte = {HIGH_RESERVED, h1}; // RULE3 RULE8
      CH1_GAIN_LOW_OFS:  read_byte = l1;                  // RULE4
      CH2_GAIN_HIGH_OFS: read_byte = {HIGH_RESERVED, h2}; // RULE5 RULE8
      CH2_GAIN_LOW_OFS:  read_byte = l2;                  // RULE6
      default:           read_byte = UNMAPPED_READ;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Edge and frame decode
  // ----------------------------------------------------------------
  wire         frame_on     = ~csb_n_s;
  wire         sclk_rise    = frame_on & sclk_s & ~sclk_prev;
  wire         sclk_fall    = frame_on & ~sclk_s & sclk_prev;
  wire         instr_rise   = sclk_rise & (phase == PH_INSTR);
  wire         data_rise    = sclk_rise & (phase == PH_DATA);
  wire         instr_done   = instr_rise & (bit_cnt == INSTR_LAST);
  wire         byte_done    = data_rise & (bit_cnt == DATA_LAST);
  wire [15:0]  next_instr   = {instr_shift, sdio_s};
  wire [7:0]   next_data    = {data_shift[6:0], sdio_s};
  wire         write_en     = byte_done & ~read_mode;
  wire         read_fall    = sclk_fall & (phase == PH_DATA) & read_mode;
  wire [14:0]  start_addr   = next_instr[14:0];
  wire [14:0]  next_addr    = 15'(cur_addr + ADDR_STEP);
  wire [7:0]   start_byte   = read_byte(start_addr,
                                        gain_high[0], gain_low[0],
                                        gain_high[1], gain_low[1],
                                        gain_high[2], gain_low[2]);
  wire [7:0]   stream_byte  = read_byte(next_addr,
                                        gain_high[0], gain_low[0],
                                        gain_high[1], gain_low[1],
                                        gain_high[2], gain_low[2]);

  // ----------------------------------------------------------------
  // Frame phase
  // ----------------------------------------------------------------
  always_comb
  begin
    next_phase = phase;
    case (phase)
      PH_IDLE:
      begin
        if (frame_on)
          next_phase = PH_INSTR;
      end
      PH_INSTR:
      begin
        if (!frame_on)
          next_phase = PH_IDLE;
        else if (instr_done)
          next_phase = PH_DATA;
      end
      PH_DATA:
      begin
        if (!frame_on)
          next_phase = PH_IDLE;
      end
      default:
        next_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      phase     <= PH_IDLE;
      sclk_prev <= 1'b0;
    end
    else
    begin
      phase     <= next_phase;
      sclk_prev <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      bit_cnt <= CNT_ZERO;
    else if (!frame_on)
      bit_cnt <= CNT_ZERO;
    else if (instr_done || byte_done)
      bit_cnt <= CNT_ZERO;
    else if (sclk_rise)
      bit_cnt <= 5'(bit_cnt + CNT_ONE);
  end

  // ----------------------------------------------------------------
  // Instruction and data shifters
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      instr_shift <= '0;
      data_shift  <= '0;
    end
    else
    begin
      if (instr_rise)
        instr_shift <= next_instr[14:0];
      if (data_rise)
        data_shift <= next_data;
    end
  end

  // Address steps up after every byte so a frame may stream
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cur_addr  <= '0;
      read_mode <= 1'b0;
    end
    else if (instr_done)
    begin
      cur_addr  <= start_addr;
      read_mode <= next_instr[INSTR_READ_BIT];
    end
    else if (byte_done)
      cur_addr <= next_addr;
  end

  // ----------------------------------------------------------------
  // Gain registers
  // ----------------------------------------------------------------
  // Partial bytes cut off by chip select are dropped, never written
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        gain_high[i] <= GAIN_HIGH_RESET; // RULE8
        gain_low[i]  <= GAIN_LOW_RESET;  // RULE8
      end
    end
    else if (write_en)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (cur_addr == high_ofs(i))
          gain_high[i] <= next_data[1:0]; // RULE1 RULE3 RULE5 RULE8
        if (cur_addr == low_ofs(i))
          gain_low[i] <= next_data;       // RULE2 RULE4 RULE6
      end
    end
  end

  // ----------------------------------------------------------------
  // Readback path
  // ----------------------------------------------------------------
  // Bits leave on the falling clock so the host samples them settled
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      out_shift <= '0;
    else if (instr_done)
      out_shift <= start_byte;
    else if (byte_done)
      out_shift <= stream_byte;
    else if (read_fall)
      out_shift <= {out_shift[6:0], 1'b0};
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      spi_sdio_out      <= 1'b0;
      spi_sdio_oe_n_out <= 1'b1;
    end
    else if (!frame_on)
    begin
      spi_sdio_out      <= 1'b0;
      spi_sdio_oe_n_out <= 1'b1;
    end
    else if (read_fall)
    begin
      spi_sdio_out      <= out_shift[7];
      spi_sdio_oe_n_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assembled codes
  // ----------------------------------------------------------------
  // Codes pass on as raw twos complement; current mapping is analog
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ch0_fullscale_code_out <= '0;
      ch1_fullscale_code_out <= '0;
      ch2_fullscale_code_out <= '0;
    end
    else
    begin
      ch0_fullscale_code_out <= {gain_high[0], gain_low[0]}; // RULE7
      ch1_fullscale_code_out <= {gain_high[1], gain_low[1]}; // RULE7
      ch2_fullscale_code_out <= {gain_high[2], gain_low[2]}; // RULE7
    end
  end

endmodule

// ===== sim/dac_gain_properties.sv
module dac_gain_checker
  import dac_gain_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       reset_in,
  input wire logic       spi_sclk_in,
  input wire logic       spi_csb_n_in,
  input wire logic       spi_sdio_in,
  input wire logic       spi_sdio_out,
  input wire logic       spi_sdio_oe_n_out,
  input wire logic [9:0] ch0_fullscale_code_out,
  input wire logic [9:0] ch1_fullscale_code_out,
  input wire logic [9:0] ch2_fullscale_code_out
);
  // ----------------------------------------------------------------
  // Idle tracking
  // ----------------------------------------------------------------
  // Threshold covers synchroniser plus write latency after the last edge
  logic [3:0] idle_cnt;
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      idle_cnt <= 4'h0;
    else if (!spi_csb_n_in)
      idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hf)
      idle_cnt <= idle_cnt + 4'h1;
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_quiet;
    idle_cnt >= 4'h8;
  endsequence
  property p_reset_clear;
    $fell(reset_in) |-> (ch0_fullscale_code_out == 10'h000) &&
      (ch1_fullscale_code_out == 10'h000) && (ch2_fullscale_code_out == 10'h000);
  endproperty
  property p_ch0_quiet; s_quiet |-> $stable(ch0_fullscale_code_out); endproperty
  property p_ch1_quiet; s_quiet |-> $stable(ch1_fullscale_code_out); endproperty
  property p_ch2_quiet; s_quiet |-> $stable(ch2_fullscale_code_out); endproperty
  property p_ch0_byte;
    $changed(ch0_fullscale_code_out) |->
      $stable(ch0_fullscale_code_out[9:8]) || $stable(ch0_fullscale_code_out[7:0]);
  endproperty
  property p_ch1_byte;
    $changed(ch1_fullscale_code_out) |->
      $stable(ch1_fullscale_code_out[9:8]) || $stable(ch1_fullscale_code_out[7:0]);
  endproperty
  property p_ch2_byte;
    $changed(ch2_fullscale_code_out) |->
      $stable(ch2_fullscale_code_out[9:8]) || $stable(ch2_fullscale_code_out[7:0]);
  endproperty
  property p_oe_idle;
    s_quiet |-> spi_sdio_oe_n_out && !spi_sdio_out;
  endproperty

  a_reset_clear: assert property (p_reset_clear) else $error("codes not clear");
  a_ch0_quiet: assert property (p_ch0_quiet) else $error("ch0 code moved");
  a_ch1_quiet: assert property (p_ch1_quiet) else $error("ch1 code moved");
  a_ch2_quiet: assert property (p_ch2_quiet) else $error("ch2 code moved");
  a_ch0_byte: assert property (p_ch0_byte) else $error("ch0 both bytes");
  a_ch1_byte: assert property (p_ch1_byte) else $error("ch1 both bytes");
  a_ch2_byte: assert property (p_ch2_byte) else $error("ch2 both bytes");
  a_oe_idle: assert property (p_oe_idle) else $error("data pin driven idle");
endmodule

bind dac_fullscale_gain_regs dac_gain_checker u_chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .spi_sclk_in(spi_sclk_in),
  .spi_csb_n_in(spi_csb_n_in), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out),
  .spi_sdio_oe_n_out(spi_sdio_oe_n_out), .ch0_fullscale_code_out(ch0_fullscale_code_out),
  .ch1_fullscale_code_out(ch1_fullscale_code_out),
  .ch2_fullscale_code_out(ch2_fullscale_code_out));

// ===== sim/dac_fullscale_gain_regs_tb.sv
module dac_fullscale_gain_regs_tb
  import dac_gain_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk, reset, sclk, csb_n, tb_sdio, sdio_out, oe_n;
  logic       sdio_wire;
  logic [9:0] code [3];
  int         err_count, samples_checked;
  logic [14:0] hi_ofs [3] = '{CH0_GAIN_HIGH_OFS, CH1_GAIN_HIGH_OFS, CH2_GAIN_HIGH_OFS};
  logic [7:0]  wh [3] = '{8'hfe, 8'h01, 8'hff};
  logic [7:0]  wl [3] = '{8'h00, 8'hff, 8'ha5};
  logic [9:0]  ex [3] = '{10'h200, 10'h1ff, 10'h3a5};

  // Device drives the shared pin only while its enable is low
  assign sdio_wire = oe_n ? tb_sdio : sdio_out;

  dac_fullscale_gain_regs DUT (
    .sys_clk_in(sys_clk), .reset_in(reset), .spi_sclk_in(sclk), .spi_csb_n_in(csb_n),
    .spi_sdio_in(sdio_wire), .spi_sdio_out(sdio_out), .spi_sdio_oe_n_out(oe_n),
    .ch0_fullscale_code_out(code[0]), .ch1_fullscale_code_out(code[1]),
    .ch2_fullscale_code_out(code[2]));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
      err_count++;
    end
  endtask

  // Eight system clocks per phase keeps the synchronisers comfortably ahead
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] wd,
                      input int nb, output logic [15:0] rdat);
    logic [31:0] sh;
    sh = {rd, a, wd};
    rdat = 16'h0000;
    @(negedge sys_clk) csb_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 16 + 8 * nb; i++)
    begin
      sclk = 1'b0;
      tb_sdio = sh[31-i];
      repeat (8) @(negedge sys_clk);
      if (i >= 16)
      begin
        rdat = {rdat[14:0], sdio_wire};
        check(16'(oe_n), 16'(!rd));
      end
      sclk = 1'b1;
      repeat (8) @(negedge sys_clk);
    end
    csb_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [15:0] d;
    for (int c = 0; c < 3; c++)
    begin
      xfer(1'b1, hi_ofs[c], 16'h0000, 2, d);
      check(d, 16'h0000);
      check(16'(code[c]), 16'h0000);
    end
  endtask

  task automatic t_write_read();
    logic [15:0] d;
    for (int c = 0; c < 3; c++)
    begin
      xfer(1'b0, hi_ofs[c], {wh[c], wl[c]}, 2, d);
      check(16'(code[c]), 16'(ex[c]));
      xfer(1'b1, hi_ofs[c], 16'h0000, 2, d);
      check(d, {6'h00, wh[c][1:0], wl[c]});
    end
    xfer(1'b0, CH1_GAIN_LOW_OFS, 16'h8000, 1, d);
    check(16'(code[1]), 16'h0180);
    check(16'(code[0]), 16'h0200);
  endtask

  task automatic t_unmapped();
    logic [15:0] d;
    xfer(1'b0, 15'h046, 16'h5555, 2, d);
    xfer(1'b1, 15'h046, 16'h0000, 2, d);
    check(d, 16'h0000);
    check(16'(code[2]), 16'h03a5);
  endtask

  task automatic t_mid_reset();
    logic [15:0] d;
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(16'(code[0]), 16'h0000);
    check(16'(code[1]), 16'h0000);
    check(16'(code[2]), 16'h0000);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    xfer(1'b1, CH2_GAIN_HIGH_OFS, 16'h0000, 2, d);
    check(d, 16'h0000);
  endtask

  task automatic summarize();
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    err_count = 0;
    samples_checked = 0;
    reset = 1'b1;
    sclk = 1'b1;
    csb_n = 1'b1;
    tb_sdio = 1'b0;
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_write_read();
    t_unmapped();
    t_mid_reset();
    summarize();
  end

  initial
  begin
    #2000000;
    err_count++;
    summarize();
  end
endmodule
